// >>> logic/srpc_top.sv
// Top: register slave, module standby, shared pin routing and data inversion
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module srpc_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sub_clk,
	input wire logic sub_mode,
	input wire logic tx_data,
	input wire logic gpio_out,
	input wire logic gpio_oe,
	input wire logic pin_i,
	input wire logic rx_pin,
	output logic pin_o,
	output logic pin_oe,
	output logic gpio_in,
	output logic rx_data,
	output logic unit_enable,
	output logic transmitter_enable,
	output logic [1:0] prescaler_select,
	output logic bit_tick,
	output logic serial_clk
);

	typedef struct packed {
		srpc_pkg::srpc_wr_st_t wr_st;
		srpc_pkg::srpc_rd_st_t rd_st;
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [7:0] w_data;
		logic w_lane0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] clk_stop;
		logic tx_sel;
		logic tx_inv;
		logic rx_inv;
		logic [7:0] divisor;
		logic [1:0] psel;
		logic tx_en;
		logic sub_prev;
		logic pin_o;
		logic pin_oe;
		logic gpio_in;
		logic rx_data;
	} srpc_state_t;

	localparam srpc_state_t ST_RST = '{
		wr_st: srpc_pkg::SRPC_WR_IDLE,
		rd_st: srpc_pkg::SRPC_RD_IDLE,
		awready: 1'b1,
		wready: 1'b1,
		arready: 1'b1,
		clk_stop: srpc_pkg::CLK_STOP_RST,
		divisor: srpc_pkg::DIVISOR_RST,
		psel: srpc_pkg::PSEL_RST,
		default: '0
	};

	srpc_state_t q;
	srpc_state_t d;
	logic [srpc_pkg::SYNC_W-1:0] sync_q;
	logic standby;
	logic sub_rise;

	////////////////////////////////////////////////////////////////////////
	// Address decode and read word
	function automatic logic srpc_mapped(input logic [7:0] a);
		logic hit;
		hit = 1'b0;
		case (a[7:2])
			srpc_pkg::OFS_CLK_STOP[7:2],
			srpc_pkg::OFS_PIN_CTRL[7:2],
			srpc_pkg::OFS_DIVISOR[7:2],
			srpc_pkg::OFS_MODE[7:2],
			srpc_pkg::OFS_CTRL[7:2],
			srpc_pkg::OFS_STATUS[7:2]: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction : srpc_mapped

	function automatic logic [31:0] srpc_rd_word(input logic [7:0] a, input srpc_state_t s,
			input logic [srpc_pkg::SYNC_W-1:0] pins);
		logic [7:0] v;
		v = 8'h00;
		case (a[7:2])
			srpc_pkg::OFS_CLK_STOP[7:2]: v = s.clk_stop;
			srpc_pkg::OFS_PIN_CTRL[7:2]: begin
				v = srpc_pkg::PIN_CTRL_ONES;
				v[srpc_pkg::PC_TX_SEL_BIT] = s.tx_sel;
				v[srpc_pkg::PC_TX_INV_BIT] = s.tx_inv;
				v[srpc_pkg::PC_RX_INV_BIT] = s.rx_inv;
			end
			srpc_pkg::OFS_DIVISOR[7:2]: v = s.divisor;
			srpc_pkg::OFS_MODE[7:2]: v[1:0] = s.psel;
			srpc_pkg::OFS_CTRL[7:2]: v[srpc_pkg::CTRL_TX_EN_BIT] = s.tx_en;
			srpc_pkg::OFS_STATUS[7:2]: begin
				v[srpc_pkg::ST_STANDBY_BIT] = ~s.clk_stop[srpc_pkg::CS_SERIAL_STOP_BIT];
				v[srpc_pkg::ST_PIN_BIT] = pins[srpc_pkg::SYNC_PIN];
				v[srpc_pkg::ST_RX_BIT] = pins[srpc_pkg::SYNC_RX];
			end
			default: v = 8'h00;
		endcase
		return {24'h00_0000, v};
	endfunction : srpc_rd_word

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		d = q;
		case (q.wr_st)
			srpc_pkg::SRPC_WR_IDLE: begin
				if (s_axi_awvalid && q.awready) begin
					d.aw_have = 1'b1;
					d.aw_addr = s_axi_awaddr;
				end
				if (s_axi_wvalid && q.wready) begin
					d.w_have = 1'b1;
					d.w_data = s_axi_wdata[7:0];
					d.w_lane0 = s_axi_wstrb[0];
				end
				if (d.aw_have && d.w_have) begin
					d.aw_have = 1'b0;
					d.w_have = 1'b0;
					d.bvalid = 1'b1;
					d.bresp = srpc_mapped(d.aw_addr) ? srpc_pkg::RESP_OKAY : srpc_pkg::RESP_DECERR;
					d.wr_st = srpc_pkg::SRPC_WR_RESP;
					if (d.w_lane0) begin
						case (d.aw_addr[7:2])
							srpc_pkg::OFS_CLK_STOP[7:2]: d.clk_stop = d.w_data | srpc_pkg::CLK_STOP_ONES;
							srpc_pkg::OFS_PIN_CTRL[7:2]: begin
								d.tx_sel = d.w_data[srpc_pkg::PC_TX_SEL_BIT];
								d.tx_inv = d.w_data[srpc_pkg::PC_TX_INV_BIT];
								d.rx_inv = d.w_data[srpc_pkg::PC_RX_INV_BIT];
							end
							srpc_pkg::OFS_DIVISOR[7:2]: d.divisor = d.w_data;
							srpc_pkg::OFS_MODE[7:2]: d.psel = d.w_data[1:0];
							srpc_pkg::OFS_CTRL[7:2]: d.tx_en = d.w_data[srpc_pkg::CTRL_TX_EN_BIT];
							default: d.bresp = d.bresp;
						endcase
					end
				end
			end
			srpc_pkg::SRPC_WR_RESP: begin
				if (s_axi_bready) begin
					d.bvalid = 1'b0;
					d.wr_st = srpc_pkg::SRPC_WR_IDLE;
				end
			end
			default: d.wr_st = srpc_pkg::SRPC_WR_IDLE;
		endcase
		d.awready = d.wr_st == srpc_pkg::SRPC_WR_IDLE && !d.aw_have;
		d.wready = d.wr_st == srpc_pkg::SRPC_WR_IDLE && !d.w_have;

		case (q.rd_st)
			srpc_pkg::SRPC_RD_IDLE: begin
				if (s_axi_arvalid && q.arready) begin
					d.rvalid = 1'b1;
					d.rdata = srpc_rd_word(s_axi_araddr, q, sync_q);
					d.rresp = srpc_mapped(s_axi_araddr) ? srpc_pkg::RESP_OKAY : srpc_pkg::RESP_DECERR;
					d.rd_st = srpc_pkg::SRPC_RD_DATA;
				end
			end
			srpc_pkg::SRPC_RD_DATA: begin
				if (s_axi_rready) begin
					d.rvalid = 1'b0;
					d.rd_st = srpc_pkg::SRPC_RD_IDLE;
				end
			end
			default: d.rd_st = srpc_pkg::SRPC_RD_IDLE;
		endcase
		d.arready = d.rd_st == srpc_pkg::SRPC_RD_IDLE;

		if (standby) begin
			d.tx_sel = 1'b0;
			d.tx_inv = 1'b0;
			d.rx_inv = 1'b0;
			d.divisor = srpc_pkg::DIVISOR_RST;
			d.psel = srpc_pkg::PSEL_RST;
			d.tx_en = 1'b0;
		end

		d.sub_prev = sync_q[srpc_pkg::SYNC_SUB];
		if (q.tx_sel) begin
			d.pin_o = tx_data ^ q.tx_inv;
			d.pin_oe = 1'b1;
		end else begin
			d.pin_o = gpio_out;
			d.pin_oe = gpio_oe;
		end
		d.gpio_in = sync_q[srpc_pkg::SYNC_PIN];
		d.rx_data = sync_q[srpc_pkg::SYNC_RX] ^ q.rx_inv;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= ST_RST;
		end else if (ce) begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Standby, synchroniser and rate generator
	assign standby = ~q.clk_stop[srpc_pkg::CS_SERIAL_STOP_BIT];
	assign sub_rise = sync_q[srpc_pkg::SYNC_SUB] & ~q.sub_prev;

	srpc_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.din({sub_clk, rx_pin, pin_i}),
		.dout(sync_q)
	);

	srpc_rate_gen u_rate (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.clear(standby),
		.sel(q.psel),
		.divisor(q.divisor),
		.sub_mode(sub_mode),
		.sub_rise(sub_rise),
		.bit_tick(bit_tick),
		.serial_clk(serial_clk)
	);

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign pin_o = q.pin_o;
	assign pin_oe = q.pin_oe;
	assign gpio_in = q.gpio_in;
	assign rx_data = q.rx_data;
	assign unit_enable = q.clk_stop[srpc_pkg::CS_SERIAL_STOP_BIT];
	assign transmitter_enable = q.tx_en;
	assign prescaler_select = q.psel;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	chk_pin_ones_read: assert property (
		(ce && s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == srpc_pkg::OFS_PIN_CTRL[7:2])
		|=> (s_axi_rvalid && s_axi_rdata[7:6] == 2'b11 && s_axi_rdata[4] == 1'b0))
		else $error("pin control fixed bits read wrong");

	chk_standby_init: assert property (
		(ce && standby) |=> (q.divisor == srpc_pkg::DIVISOR_RST && !q.tx_sel && !q.tx_inv
		&& !q.rx_inv && q.psel == srpc_pkg::PSEL_RST && !q.tx_en))
		else $error("unit register not at initial value in standby");

	chk_reset_values: assert property (
		$rose(aresetn) |-> (unit_enable && q.divisor == srpc_pkg::DIVISOR_RST && !pin_oe))
		else $error("reset values wrong after reset release");

	chk_tx_route: assert property (
		(ce && q.tx_sel) |=> (pin_oe && pin_o == ($past(tx_data) ^ $past(q.tx_inv))))
		else $error("transmit data not on shared pin");

	chk_gpio_route: assert property (
		(ce && !q.tx_sel) |=> (pin_o == $past(gpio_out) && pin_oe == $past(gpio_oe)))
		else $error("port data not on shared pin");

	chk_rx_invert: assert property (
		ce |=> rx_data == ($past(sync_q[srpc_pkg::SYNC_RX]) ^ $past(q.rx_inv)))
		else $error("receive data inversion wrong");

	chk_standby_silent: assert property (
		(ce && standby) |=> (!bit_tick && !serial_clk))
		else $error("rate generator running in standby");

endmodule : srpc_top
`default_nettype wire

// >>> logic/srpc_pkg.sv
// Package: register map, field positions, reset values and codes of the serial rate and pin control block
package srpc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFS_CLK_STOP = 8'h00;
	localparam logic [7:0] OFS_PIN_CTRL = 8'h04;
	localparam logic [7:0] OFS_DIVISOR = 8'h08;
	localparam logic [7:0] OFS_MODE = 8'h0c;
	localparam logic [7:0] OFS_CTRL = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CS_SERIAL_STOP_BIT = 5;
	localparam int PC_TX_SEL_BIT = 5;
	localparam int PC_TX_INV_BIT = 3;
	localparam int PC_RX_INV_BIT = 2;
	localparam int CTRL_TX_EN_BIT = 5;
	localparam int ST_STANDBY_BIT = 0;
	localparam int ST_PIN_BIT = 1;
	localparam int ST_RX_BIT = 2;

	////////////////////////////////////////////////////////////////////////
	// Reset values and fixed bits
	localparam logic [7:0] CLK_STOP_RST = 8'hff;
	localparam logic [7:0] CLK_STOP_ONES = 8'hc0;
	localparam logic [7:0] PIN_CTRL_ONES = 8'hc0;
	localparam logic [7:0] DIVISOR_RST = 8'hff;
	localparam logic [1:0] PSEL_RST = 2'h0;

	////////////////////////////////////////////////////////////////////////
	// Prescaler codes and rate generator counts
	localparam logic [1:0] PSEL_SYS = 2'h0;
	localparam logic [1:0] PSEL_SUB = 2'h1;
	localparam logic [1:0] PSEL_DIV16 = 2'h2;
	localparam logic [1:0] PSEL_DIV64 = 2'h3;
	localparam logic [5:0] PRE16_MASK = 6'h0f;
	localparam logic [5:0] PRE64_MASK = 6'h3f;
	localparam logic [1:0] LAST_QUARTER = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Synchroniser lanes
	localparam int SYNC_W = 3;
	localparam int SYNC_PIN = 0;
	localparam int SYNC_RX = 1;
	localparam int SYNC_SUB = 2;

	////////////////////////////////////////////////////////////////////////
	// Bus answers and channel states
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		SRPC_WR_IDLE = 2'b01,
		SRPC_WR_RESP = 2'b10
	} srpc_wr_st_t;

	typedef enum logic [1:0] {
		SRPC_RD_IDLE = 2'b01,
		SRPC_RD_DATA = 2'b10
	} srpc_rd_st_t;

endpackage : srpc_pkg

// >>> logic/srpc_sync.sv
// Two-flop synchroniser for the pin and sub-clock inputs
`timescale 1ns/10ps
`default_nettype none
module srpc_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [srpc_pkg::SYNC_W-1:0] din,
	output logic [srpc_pkg::SYNC_W-1:0] dout
);

	typedef struct packed {
		logic [srpc_pkg::SYNC_W-1:0] s1;
		logic [srpc_pkg::SYNC_W-1:0] s2;
	} srpc_sync_state_t;

	srpc_sync_state_t q;
	srpc_sync_state_t d;

	always_comb begin
		d.s1 = din;
		d.s2 = q.s1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign dout = q.s2;

endmodule : srpc_sync
`default_nettype wire

// >>> logic/srpc_rate_gen.sv
// Bit rate generator: prescaler, divisor counter and quarter-bit stage
`timescale 1ns/10ps
`default_nettype none
module srpc_rate_gen (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic clear,
	input wire logic [1:0] sel,
	input wire logic [7:0] divisor,
	input wire logic sub_mode,
	input wire logic sub_rise,
	output logic bit_tick,
	output logic serial_clk
);

	typedef struct packed {
		logic [5:0] pre;
		logic half;
		logic [7:0] div;
		logic [1:0] quarter;
		logic tick;
		logic sclk;
	} srpc_rg_state_t;

	localparam srpc_rg_state_t RG_RST = '0;

	srpc_rg_state_t q;
	srpc_rg_state_t d;
	logic tick_in;
	logic [16:0] gap_q;
	logic steady_q;
	logic [1:0] sel_q;
	logic [7:0] divisor_q;

	////////////////////////////////////////////////////////////////////////
	// Input clock selection and divider chain
	always_comb begin
		d = q;
		d.tick = 1'b0;
		tick_in = 1'b0;
		d.pre = q.pre + 6'h01;
		case (sel)
			srpc_pkg::PSEL_SYS: tick_in = 1'b1;
			srpc_pkg::PSEL_SUB: begin
				if (sub_rise) begin
					tick_in = sub_mode | q.half;
					d.half = ~q.half;
				end
			end
			srpc_pkg::PSEL_DIV16: tick_in = (q.pre & srpc_pkg::PRE16_MASK) == srpc_pkg::PRE16_MASK;
			srpc_pkg::PSEL_DIV64: tick_in = q.pre == srpc_pkg::PRE64_MASK;
			default: tick_in = 1'b0;
		endcase
		if (tick_in) begin
			if (q.div >= divisor) begin
				d.div = 8'h00;
				d.quarter = q.quarter + 2'h1;
				d.sclk = q.quarter[0] ? ~q.sclk : q.sclk;
				d.tick = q.quarter == srpc_pkg::LAST_QUARTER;
			end else begin
				d.div = q.div + 8'h01;
			end
		end
		if (clear) begin
			d = RG_RST;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= RG_RST;
		end else if (ce) begin
			q <= d;
		end
	end

	assign bit_tick = q.tick;
	assign serial_clk = q.sclk;

	////////////////////////////////////////////////////////////////////////
	// Checks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gap_q <= 17'h0_0000;
			steady_q <= 1'b0;
			sel_q <= srpc_pkg::PSEL_RST;
			divisor_q <= srpc_pkg::DIVISOR_RST;
		end else begin
			sel_q <= sel;
			divisor_q <= divisor;
			gap_q <= q.tick ? 17'h0_0001 : gap_q + 17'h0_0001;
			if (!ce || clear || sel != sel_q || divisor != divisor_q) begin
				steady_q <= 1'b0;
			end else if (q.tick) begin
				steady_q <= 1'b1;
			end
		end
	end

	chk_bit_period_sys: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.tick && steady_q && ce && sel == srpc_pkg::PSEL_SYS && sel == sel_q && divisor == divisor_q)
		|-> gap_q == ((17'(divisor) + 17'h0_0001) << 2))
		else $error("bit period differs from four times divisor plus one");

	chk_divisor_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && !clear && tick_in && q.div == divisor) |=> q.div == 8'h00)
		else $error("divisor counter did not wrap at the programmed value");

	chk_presc_sel: assert property (@(posedge aclk) disable iff (!aresetn)
		((sel == srpc_pkg::PSEL_DIV16 || sel == srpc_pkg::PSEL_DIV64) && tick_in)
		|-> (q.pre[3:0] == 4'hf && (sel == srpc_pkg::PSEL_DIV16 || q.pre[5:4] == 2'h3)))
		else $error("prescaler tick at wrong count");

	chk_sub_active_half: assert property (@(posedge aclk) disable iff (!aresetn)
		(sel == srpc_pkg::PSEL_SUB && !sub_mode && tick_in) |-> (sub_rise && q.half))
		else $error("sub-clock not halved in active mode");

	chk_sub_direct: assert property (@(posedge aclk) disable iff (!aresetn)
		(sel == srpc_pkg::PSEL_SUB && sub_mode && sub_rise) |-> tick_in)
		else $error("sub-clock edge lost in subactive mode");

endmodule : srpc_rate_gen
`default_nettype wire

// >>> tb/srpc_peer.sv
// Remote serial peer on the receive pin and the shared transmit pin
`timescale 1ns/10ps
`default_nettype none
module srpc_peer (
	input wire logic aclk,
	input wire logic line_o,
	input wire logic line_oe,
	input wire logic send_bit,
	output logic rx_line,
	output logic pin_level
);
	////////////////////////////////////////////////////////////////////////
	// Shared pin is pulled up while nobody drives it
	assign pin_level = line_oe ? line_o : 1'b1;
	// Peer launches its receive data just after the rising edge
	initial begin
		rx_line = 1'b1;
		forever begin
			@(posedge aclk);
			rx_line <= send_bit;
		end
	end
endmodule : srpc_peer
`default_nettype wire

// >>> tb/serial_rate_and_pin_control_bench.sv
// Testbench: register, rate, pin routing and standby tests over AXI4-Lite
`timescale 1ns/10ps
`default_nettype none
module serial_rate_and_pin_control_bench;
	logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, prescaler_select;
	logic sub_clk, sub_mode, tx_data, gpio_out, gpio_oe, pin_i, rx_pin, pin_o, pin_oe, gpio_in, rx_data;
	logic unit_enable, transmitter_enable, bit_tick, serial_clk, send_bit;
	logic [31:0] v;
	int n_fail, comparisons, p;

	srpc_top uut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sub_clk(sub_clk), .sub_mode(sub_mode), .tx_data(tx_data), .gpio_out(gpio_out),
		.gpio_oe(gpio_oe), .pin_i(pin_i), .rx_pin(rx_pin), .pin_o(pin_o), .pin_oe(pin_oe), .gpio_in(gpio_in),
		.rx_data(rx_data), .unit_enable(unit_enable), .transmitter_enable(transmitter_enable),
		.prescaler_select(prescaler_select), .bit_tick(bit_tick), .serial_clk(serial_clk));
	srpc_peer peer (.aclk(aclk), .line_o(pin_o), .line_oe(pin_oe), .send_bit(send_bit), .rx_line(rx_pin),
		.pin_level(pin_i));

	////////////////////////////////////////////////////////////////////////
	// Clocks: system clock and a sub-clock with a six-cycle period
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		sub_clk = 1'b0;
		forever begin
			repeat (3) @(posedge aclk);
			sub_clk <= ~sub_clk;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Compare, report and bus tasks
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task summarize;
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize
	task wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (n < 100) begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				bready <= 1'b0;
				chk("write response", {30'h0, bresp}, {30'h0, srpc_pkg::RESP_OKAY});
				n = 200;
			end
		end
		if (n == 100) chk("write timeout", 32'h0000_0001, 32'h0000_0000);
	endtask : wr
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (n < 100) begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				rready <= 1'b0;
				chk(nm, rdata, exp);
				chk("read response", {30'h0, rresp}, {30'h0, er});
				n = 200;
			end
		end
		if (n == 100) chk("read timeout", 32'h0000_0001, 32'h0000_0000);
	endtask : rdc
	task per;
		int n, last, k;
		n = 0;
		last = 0;
		k = 0;
		p = 0;
		while (k < 3 && n < 4000) begin
			@(posedge aclk);
			n++;
			if (bit_tick === 1'b1) begin
				p = n - last;
				last = n;
				k++;
			end
		end
		chk("tick count", k, 32'h0000_0003);
	endtask : per
	task done(input string nm);
		$display("Test %s finished", nm);
	endtask : done

	////////////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		repeat (60000) @(posedge aclk);
		n_fail++;
		summarize();
	end

	////////////////////////////////////////////////////////////////////////
	// Tests
	localparam logic [1:0] TP[7] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h3, 2'h1, 2'h1};
	localparam logic [7:0] TD[7] = '{8'h00, 8'h05, 8'hff, 8'h00, 8'h01, 8'h01, 8'h01};
	localparam logic TM[7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
	localparam int TE[7] = '{4, 24, 1024, 64, 512, 48, 96};
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, sub_mode, tx_data, gpio_out, gpio_oe, send_bit} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'h1;
		ce = 1'b1;
		n_fail = 0;
		comparisons = 0;
		aresetn = 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rdc("clock stop", srpc_pkg::OFS_CLK_STOP, 32'h0000_00ff, 2'h0);
		rdc("pin control", srpc_pkg::OFS_PIN_CTRL, 32'h0000_00c0, 2'h0);
		rdc("divisor", srpc_pkg::OFS_DIVISOR, 32'h0000_00ff, 2'h0);
		rdc("mode", srpc_pkg::OFS_MODE, 32'h0000_0000, 2'h0);
		rdc("unmapped", 8'h18, 32'h0000_0000, srpc_pkg::RESP_DECERR);
		done("reset values");
		wr(srpc_pkg::OFS_PIN_CTRL, 8'h2c);
		rdc("pin control", srpc_pkg::OFS_PIN_CTRL, 32'h0000_00ec, 2'h0);
		wr(srpc_pkg::OFS_PIN_CTRL, 8'h00);
		rdc("pin control", srpc_pkg::OFS_PIN_CTRL, 32'h0000_00c0, 2'h0);
		wr(srpc_pkg::OFS_DIVISOR, 8'h00);
		rdc("divisor", srpc_pkg::OFS_DIVISOR, 32'h0000_0000, 2'h0);
		wr(srpc_pkg::OFS_DIVISOR, 8'ha5);
		rdc("divisor", srpc_pkg::OFS_DIVISOR, 32'h0000_00a5, 2'h0);
		wstrb <= 4'h0;
		wr(srpc_pkg::OFS_DIVISOR, 8'h5a);
		wstrb <= 4'h1;
		rdc("masked divisor", srpc_pkg::OFS_DIVISOR, 32'h0000_00a5, 2'h0);
		done("register access");
		for (int i = 0; i < 7; i++) begin
			sub_mode <= TM[i];
			wr(srpc_pkg::OFS_MODE, {6'h00, TP[i]});
			wr(srpc_pkg::OFS_DIVISOR, TD[i]);
			chk("prescaler select", {30'h0, prescaler_select}, {30'h0, TP[i]});
			per();
			chk("bit period", p, TE[i]);
		end
		sub_mode <= 1'b0;
		done("bit rate");
		gpio_oe <= 1'b1;
		repeat (6) @(posedge aclk);
		chk("port drive", {pin_oe, pin_o, gpio_in}, 32'h0000_0004);
		wr(srpc_pkg::OFS_PIN_CTRL, 8'h20);
		wr(srpc_pkg::OFS_CTRL, 8'h20);
		tx_data <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("transmit drive", {transmitter_enable, pin_oe, pin_o}, 32'h0000_0007);
		wr(srpc_pkg::OFS_PIN_CTRL, 8'h28);
		repeat (3) @(posedge aclk);
		chk("inverted transmit", {pin_oe, pin_o}, 32'h0000_0002);
		for (int i = 0; i < 4; i++) begin
			wr(srpc_pkg::OFS_PIN_CTRL, (i > 1) ? 8'h24 : 8'h20);
			send_bit <= i[0];
			repeat (6) @(posedge aclk);
			chk("receive data", rx_data, i[0] ^ i[1]);
		end
		done("pin routing");
		wr(srpc_pkg::OFS_DIVISOR, 8'h10);
		wr(srpc_pkg::OFS_CLK_STOP, 8'hdf);
		repeat (2) @(posedge aclk);
		chk("standby outputs", {unit_enable, transmitter_enable}, 32'h0000_0000);
		wr(srpc_pkg::OFS_DIVISOR, 8'h33);
		rdc("divisor", srpc_pkg::OFS_DIVISOR, 32'h0000_00ff, 2'h0);
		rdc("pin control", srpc_pkg::OFS_PIN_CTRL, 32'h0000_00c0, 2'h0);
		rdc("ctrl", srpc_pkg::OFS_CTRL, 32'h0000_0000, 2'h0);
		rdc("clock stop", srpc_pkg::OFS_CLK_STOP, 32'h0000_00df, 2'h0);
		rdc("status", srpc_pkg::OFS_STATUS, 32'h0000_0005, 2'h0);
		v = 0;
		repeat (300) begin
			@(posedge aclk);
			if (bit_tick !== 1'b0 || serial_clk !== 1'b0) v++;
		end
		chk("standby ticks", v, 32'h0000_0000);
		wr(srpc_pkg::OFS_CLK_STOP, 8'hff);
		repeat (2) @(posedge aclk);
		chk("unit enable", unit_enable, 32'h0000_0001);
		wr(srpc_pkg::OFS_DIVISOR, 8'h00);
		per();
		chk("bit period", p, 32'h0000_0004);
		done("module standby");
		ce <= 1'b0;
		@(posedge aclk);
		v = {30'h0, bit_tick, serial_clk};
		p = 0;
		repeat (20) begin
			@(posedge aclk);
			if ({30'h0, bit_tick, serial_clk} !== v) p++;
		end
		ce <= 1'b1;
		chk("frozen rate outputs", p, 32'h0000_0000);
		done("clock enable");
		summarize();
	end
endmodule : serial_rate_and_pin_control_bench
`default_nettype wire
